// File: rtl/cmd_regs.svh
// command decoder constants: field positions, codes and timing counts
// assumes inclusion by bare name from package and modules
`ifndef CMD_REGS_SVH
`define CMD_REGS_SVH
`define ADDR_W 14
`define BANK_W 3
`define DQ_W 16
`define LANE_W 8
`define BANK_HI 2
`define ADDR_HI 13
`define ADDR_B12 12
`define ADDR_B11 11
`define ADDR_B8 8
`define LA_HI 7
`define MRS_ZERO_HI 13
`define MRS_ZERO_LO 8
`define OP_W 10
`define READY_CLOCKS 16'd200
`define CNT_W 16
`define MASK_ALL 4'hF
`define MASK_TWO 4'h3
`define MASK_ONE 4'h1
`define MASK_NONE 4'h0
`define CLK_DIV 4'd2
`define DIV_W 4
`define PAUSE_NS 200000
`define CLK_NS 50
`define INIT_REFS 4'd2
`define SEQ_W 4
`endif

// File: rtl/cmd_pkg.sv
// types shared by both ends of the command link
// assumes cmd_regs.svh for widths
`include "cmd_regs.svh"
package cmd_pkg;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_LAL = 3'h1,
    CMD_REF = 3'h2,
    CMD_MRS = 3'h3,
    CMD_READ_ACT = 3'h4,
    CMD_WRITE_ACT = 3'h5
  } cmd_t;
endpackage

// File: rtl/cmd_link_if.sv
// link between host controller and memory command front end
// assumes link clock is driven by the host end
`timescale 1ns/1ps
`default_nettype none
`include "cmd_regs.svh"
interface cmd_link_if;
  logic linkClk;
  logic chipSelN;
  logic functionSelect;
  logic [`BANK_W-1:0] bank;
  logic [`ADDR_W-1:0] addr;
  logic powerdownCtrlN;
  logic lowByteStrobe;
  logic highByteStrobe;
  modport host (output linkClk, chipSelN, functionSelect, bank, addr, powerdownCtrlN,
    lowByteStrobe, highByteStrobe);
  modport device (input linkClk, chipSelN, functionSelect, bank, addr, powerdownCtrlN,
    lowByteStrobe, highByteStrobe);
endinterface
`default_nettype wire

// File: rtl/mem_cmd_device.sv
// memory-side command decoder, clocked by the link clock
// assumes host obeys the two-command pairing and init sequence
`timescale 1ns/1ps
`default_nettype none
`include "cmd_regs.svh"
// Behaviour
// - sample commands on rising link clock edge
// - first cycle: deselect, read or write activate
// - second command follows activate, decoded by type
// - mode write has zero high address bits
// - read lower address from bits seven down
// - write latch carries both lane length codes
// - length code sets words written per burst
// - low code low lane, high code high
// - each byte strobe times its own lane
// - host limits refresh burst density
// - host holds stable clock before init
// - host deselects and raises powerdown control
// - host writes extended mode register
// - host writes mode register
// - host sends two or more refreshes
// - init steps may come in any order
// - ready 200 clocks after extended mode write
// - host lowers powerdown with the refresh command for sleep
// - powerdown rise exits low power without clock
module mem_cmd_device
  import cmd_pkg::*;
(
  input wire logic rst,
  cmd_link_if.device link,
  input wire logic burstFour,
  output logic [2:0] cmdType,
  output logic [`BANK_W-1:0] bankOut,
  output logic [`ADDR_W-1:0] upperRowAddr,
  output logic [`LA_HI:0] lowerColAddr,
  output logic [`OP_W-1:0] modeOpcode,
  output logic modeWriteBad,
  output logic [3:0] lowWordMask,
  output logic [3:0] highWordMask,
  output logic lowLaneStrobe,
  output logic highLaneStrobe,
  output logic lowPower,
  output logic ready
);
  // ---------------------------------------------------------------
  // pair tracking
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_FIRST = 2'b00,
    ST_AFTER_READ = 2'b01,
    ST_AFTER_WRITE = 2'b10
  } pair_t;
  pair_t pair_q;
  logic emrsSeen_q;
  logic [`CNT_W-1:0] readyCnt_q;
  logic [1:0] lenLow;
  logic [1:0] lenHigh;
  assign lenLow = {link.addr[`ADDR_HI], link.bank[`BANK_HI]};
  assign lenHigh = {link.addr[`ADDR_B11], link.addr[`ADDR_B12]};

  function automatic logic [3:0] words(input logic [1:0] c, input logic b4);
    logic [3:0] m;
    m = `MASK_NONE;
    if (!b4) begin
      m = c[0] ? `MASK_ONE : `MASK_TWO;
    end else begin
      case (c)
        2'b01: m = `MASK_ALL;
        2'b10: m = `MASK_TWO;
        2'b11: m = `MASK_ONE;
        default: m = `MASK_NONE; // reserved code writes nothing
      endcase
    end
    return m;
  endfunction

  always_ff @(posedge link.linkClk or posedge rst) begin
    if (rst) begin
      pair_q <= ST_FIRST;
      cmdType <= CMD_NONE;
      bankOut <= '0;
      upperRowAddr <= '0;
      lowerColAddr <= '0;
      modeOpcode <= '0;
      modeWriteBad <= 1'b0;
      lowWordMask <= `MASK_NONE;
      highWordMask <= `MASK_NONE;
    end else begin
      cmdType <= CMD_NONE;
      case (pair_q)
        ST_FIRST: begin
          if (!link.chipSelN && link.powerdownCtrlN) begin
            cmdType <= link.functionSelect ? CMD_READ_ACT : CMD_WRITE_ACT;
            pair_q <= link.functionSelect ? ST_AFTER_READ : ST_AFTER_WRITE;
            bankOut <= link.bank;
            upperRowAddr <= link.addr;
          end
        end
        ST_AFTER_READ: begin
          pair_q <= ST_FIRST;
          if (link.chipSelN) begin
            cmdType <= CMD_LAL;
            lowerColAddr <= link.addr[`LA_HI:0];
          end else begin
            cmdType <= CMD_MRS;
            modeOpcode <= {link.bank[1:0], link.addr[`LA_HI:0]};
            modeWriteBad <= link.bank[`BANK_HI] ||
              (link.addr[`MRS_ZERO_HI:`MRS_ZERO_LO] != 6'h00);
          end
        end
        ST_AFTER_WRITE: begin
          pair_q <= ST_FIRST;
          if (link.chipSelN) begin
            cmdType <= CMD_LAL;
            lowerColAddr <= link.addr[`LA_HI:0];
            lowWordMask <= words(lenLow, burstFour);
            highWordMask <= words(lenHigh, burstFour);
          end else begin
            cmdType <= CMD_REF;
          end
        end
        default: pair_q <= ST_FIRST;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // strobe lanes and readiness
  // ---------------------------------------------------------------
  always_ff @(posedge link.linkClk or posedge rst) begin
    if (rst) begin
      lowLaneStrobe <= 1'b0;
      highLaneStrobe <= 1'b0;
    end else begin
      lowLaneStrobe <= link.lowByteStrobe;
      highLaneStrobe <= link.highByteStrobe;
    end
  end

  always_ff @(posedge link.linkClk or posedge rst) begin
    if (rst) begin
      emrsSeen_q <= 1'b0;
      readyCnt_q <= '0;
      ready <= 1'b0;
    end else begin
      if (pair_q == ST_AFTER_READ && !link.chipSelN && link.bank[`BANK_HI] == 1'b0 &&
          link.bank[0]) begin
        // extended register selected by bank bit zero; restart the count
        emrsSeen_q <= 1'b1;
        readyCnt_q <= '0;
        ready <= 1'b0;
      end else if (emrsSeen_q && readyCnt_q != `READY_CLOCKS) begin
        readyCnt_q <= readyCnt_q + 16'h0001;
      end
      if (emrsSeen_q && readyCnt_q == `READY_CLOCKS) begin
        ready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // low power: entry on clock, exit on the control's rise itself
  // ---------------------------------------------------------------
  // the control's rise clears at once, so no link edge is needed to wake
  always_ff @(posedge link.linkClk or posedge rst or posedge link.powerdownCtrlN) begin
    if (rst) begin
      lowPower <= 1'b0;
    end else if (link.powerdownCtrlN) begin
      lowPower <= 1'b0;
    end else if (pair_q == ST_AFTER_WRITE && !link.chipSelN) begin
      lowPower <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: rtl/mem_cmd_host.sv
// host controller end: makes link clock, runs init, issues command pairs
// assumes one user request at a time, held until reqAck
`timescale 1ns/1ps
`default_nettype none
`include "cmd_regs.svh"
module mem_cmd_host
  import cmd_pkg::*;
#(
  parameter int PAUSE_CLOCKS = `PAUSE_NS / `CLK_NS
)
(
  input wire logic clk,
  input wire logic rst,
  cmd_link_if.host link,
  input wire logic reqValid,
  input wire logic [2:0] reqCmd,
  input wire logic [`BANK_W-1:0] reqBank,
  input wire logic [`ADDR_W-1:0] reqAddr,
  input wire logic [`ADDR_W-1:0] reqSecond,
  input wire logic reqSleep,
  output logic reqAck,
  output logic initDone
);
  typedef enum logic [2:0] {
    H_PAUSE = 3'b000,
    H_INIT_EXTENDED_MODE_WRITE = 3'b001,
    H_INIT_MRS = 3'b010,
    H_INIT_REF = 3'b011,
    H_WAIT = 3'b100,
    H_IDLE = 3'b101,
    H_SECOND = 3'b110
  } host_t;
  host_t st_q;
  logic [`DIV_W-1:0] div_q;
  logic [19:0] cnt_q;
  logic [`SEQ_W-1:0] refs_q;
  logic [2:0] cmd_q;
  logic [`ADDR_W-1:0] second_q;
  logic sleep_q;

  // ---------------------------------------------------------------
  // link clock divider; commands change on its falling half
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      link.linkClk <= 1'b0;
    end else if (div_q == `CLK_DIV - 4'd1) begin
      div_q <= '0;
      link.linkClk <= ~link.linkClk;
    end else begin
      div_q <= div_q + 4'd1;
    end
  end
  logic tick;
  assign tick = (div_q == `CLK_DIV - 4'd1) && link.linkClk;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= H_PAUSE;
      cnt_q <= '0;
      refs_q <= '0;
      cmd_q <= CMD_NONE;
      second_q <= '0;
      sleep_q <= 1'b0;
      reqAck <= 1'b0;
      initDone <= 1'b0;
      link.chipSelN <= 1'b1;
      link.functionSelect <= 1'b0;
      link.bank <= '0;
      link.addr <= '0;
      link.powerdownCtrlN <= 1'b0;
      link.lowByteStrobe <= 1'b0;
      link.highByteStrobe <= 1'b0;
    end else begin
      reqAck <= 1'b0;
      if (tick) begin
        link.chipSelN <= 1'b1;
        link.lowByteStrobe <= 1'b0;
        link.highByteStrobe <= 1'b0;
        case (st_q)
          H_PAUSE: begin
            cnt_q <= cnt_q + 20'h00001;
            if (cnt_q >= 20'(PAUSE_CLOCKS / `CLK_DIV / 2)) begin
              link.powerdownCtrlN <= 1'b1;
              st_q <= H_INIT_EXTENDED_MODE_WRITE;
            end
          end
          H_INIT_EXTENDED_MODE_WRITE: begin
            link.chipSelN <= 1'b0;
            link.functionSelect <= 1'b1;
            second_q <= 14'h0100;
            cmd_q <= CMD_MRS;
            st_q <= H_SECOND;
            cnt_q <= '0;
          end
          H_INIT_MRS: begin
            link.chipSelN <= 1'b0;
            link.functionSelect <= 1'b1;
            second_q <= 14'h0000;
            cmd_q <= CMD_MRS;
            st_q <= H_SECOND;
          end
          H_INIT_REF: begin
            link.chipSelN <= 1'b0;
            link.functionSelect <= 1'b0;
            cmd_q <= CMD_REF;
            refs_q <= refs_q + 4'd1;
            st_q <= H_SECOND;
          end
          H_WAIT: begin
            cnt_q <= cnt_q + 20'h00001;
            if (cnt_q >= 20'(`READY_CLOCKS)) begin
              initDone <= 1'b1;
              st_q <= H_IDLE;
            end
          end
          H_IDLE: begin
            link.powerdownCtrlN <= 1'b1;
            if (reqValid && link.powerdownCtrlN) begin
              link.chipSelN <= 1'b0;
              link.functionSelect <= (reqCmd == CMD_READ_ACT || reqCmd == CMD_LAL ||
                reqCmd == CMD_MRS);
              link.bank <= reqBank;
              link.addr <= reqAddr;
              cmd_q <= reqCmd;
              second_q <= reqSecond;
              sleep_q <= reqSleep;
              reqAck <= 1'b1;
              st_q <= H_SECOND;
            end
          end
          H_SECOND: begin
            link.chipSelN <= !(cmd_q == CMD_MRS || cmd_q == CMD_REF);
            link.lowByteStrobe <= !(cmd_q == CMD_MRS || cmd_q == CMD_REF);
            link.highByteStrobe <= (cmd_q == CMD_WRITE_ACT);
            link.addr <= (cmd_q == CMD_MRS) ? {6'h00, second_q[7:0]} : second_q;
            link.bank <= (cmd_q == CMD_MRS) ? {1'b0, second_q[9:8]} : link.bank;
            if (cmd_q == CMD_REF && sleep_q && initDone) begin
              link.powerdownCtrlN <= 1'b0;
            end
            if (initDone) begin
              st_q <= H_IDLE;
            end else if (second_q == 14'h0100 && cmd_q == CMD_MRS) begin
              st_q <= H_INIT_MRS;
            end else if (refs_q < `INIT_REFS) begin
              st_q <= H_INIT_REF;
            end else begin
              st_q <= H_WAIT;
            end
          end
          default: st_q <= H_PAUSE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/cmd_link_props.sv
// checker for the command link between the host and device ends
// assumes plain link signals and the shared reset, sampled on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "cmd_regs.svh"
module cmd_link_props (
  input wire logic rst,
  input wire logic linkClk,
  input wire logic chipSelN,
  input wire logic functionSelect,
  input wire logic [`BANK_W-1:0] bank,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic powerdownCtrlN
);
  // ----------------------------------------
  // command slot tracking
  // ----------------------------------------
  logic secondQ, readKindQ, emrsSeenQ, mrsSeenQ;
  logic [7:0] gapQ;
  logic [1:0] refCntQ;
  logic [15:0] refWinQ;
  wire logic firstAct = !chipSelN && !secondQ && powerdownCtrlN;
  wire logic refSec = secondQ && !readKindQ && !chipSelN;
  wire logic mrsSec = secondQ && readKindQ && !chipSelN;
  wire logic lalSec = secondQ && chipSelN;
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      secondQ <= 1'b0;
      readKindQ <= 1'b0;
    end else begin
      secondQ <= firstAct;
      if (firstAct) begin
        readKindQ <= functionSelect;
      end
    end
  end
  // saturates so a long idle never wraps back under the limit
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      gapQ <= 8'h00;
    end else if (mrsSec && bank[0]) begin
      gapQ <= 8'h00;
    end else if (gapQ != 8'hFF) begin
      gapQ <= gapQ + 8'h01;
    end
  end
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      emrsSeenQ <= 1'b0;
      mrsSeenQ <= 1'b0;
      refCntQ <= 2'h0;
      refWinQ <= 16'h0000;
    end else begin
      emrsSeenQ <= emrsSeenQ || (mrsSec && bank[0]);
      mrsSeenQ <= mrsSeenQ || (mrsSec && !bank[0]);
      refCntQ <= (refSec && refCntQ != 2'h3) ? refCntQ + 2'h1 : refCntQ;
      refWinQ <= {refWinQ[14:0], refSec};
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (rst);
  sequence mode_wr_s;
    firstAct && functionSelect ##1 !chipSelN;
  endsequence
  a_mode_zero_bits: assert property (mode_wr_s |-> !bank[2] && addr[13:8] == 6'h00)
    else $error("mode write with nonzero reserved bits");
  a_ready_gap: assert property (lalSec |-> gapQ >= 8'hC7)
    else $error("access too soon after extended mode write");
  a_init_modes: assert property (lalSec |-> emrsSeenQ && mrsSeenQ)
    else $error("access before both mode writes");
  a_init_refresh: assert property (lalSec |-> refCntQ >= 2'h2)
    else $error("access before two refreshes");
  a_refresh_density: assert property (refSec |-> $countones({refWinQ[14:0], 1'b1}) <= 8)
    else $error("more than eight refreshes in sixteen link cycles");
  a_exit_deselect: assert property ($rose(powerdownCtrlN) |-> chipSelN)
    else $error("powerdown control raised without deselect");
  a_low_no_act: assert property (!powerdownCtrlN && !secondQ |-> chipSelN)
    else $error("chip select low while powerdown control low");
  a_sleep_entry: assert property ($fell(powerdownCtrlN) |-> refSec || $past(refSec))
    else $error("powerdown control fell away from a refresh");
endmodule
`default_nettype wire

// File: sim/tb_two_step_command_decoder.sv
// testbench: host and device ends joined by the link, driven from the host user side
// assumes the host makes the link clock and runs init by itself after reset
`timescale 1ns/1ps
`default_nettype none
`include "cmd_regs.svh"
module tb_two_step_command_decoder import cmd_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqSleep = 1'b0, burstFour = 1'b0;
  logic [2:0] reqCmd = 3'h0, reqBank = 3'h0, cmdType, bankOut;
  logic [13:0] reqAddr = 14'h0000, reqSecond = 14'h0000, upperRowAddr;
  logic [7:0] lowerColAddr;
  logic [3:0] lowWordMask, highWordMask;
  logic reqAck, initDone, modeWriteBad, lowLaneStrobe, highLaneStrobe, ready, lowPower;
  int fails = 0, cmpCount = 0, refSeen = 0, modeSeen = 0, lpSeen = 0;
  cmd_link_if cmd_link_if_inst ();
  wire logic linkClk = cmd_link_if_inst.linkClk;
  mem_cmd_host #(.PAUSE_CLOCKS(40)) mem_cmd_host_inst (.clk(clk), .rst(rst),
    .link(cmd_link_if_inst.host), .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank),
    .reqAddr(reqAddr), .reqSecond(reqSecond), .reqSleep(reqSleep), .reqAck(reqAck),
    .initDone(initDone));
  mem_cmd_device mem_cmd_device_inst (.rst(rst), .link(cmd_link_if_inst.device),
    .burstFour(burstFour), .cmdType(cmdType), .bankOut(bankOut), .upperRowAddr(upperRowAddr),
    .lowerColAddr(lowerColAddr), .modeOpcode(), .modeWriteBad(modeWriteBad),
    .lowWordMask(lowWordMask), .highWordMask(highWordMask), .lowLaneStrobe(lowLaneStrobe),
    .highLaneStrobe(highLaneStrobe), .lowPower(lowPower), .ready(ready));
  cmd_link_props cmd_link_props_inst (.rst(rst), .linkClk(cmd_link_if_inst.linkClk),
    .chipSelN(cmd_link_if_inst.chipSelN), .functionSelect(cmd_link_if_inst.functionSelect),
    .bank(cmd_link_if_inst.bank), .addr(cmd_link_if_inst.addr),
    .powerdownCtrlN(cmd_link_if_inst.powerdownCtrlN));
  always #25 clk = ~clk;
  always @(posedge linkClk) begin
    if (cmdType === 3'h2) refSeen++;
    if (cmdType === 3'h3) modeSeen++;
  end
  always @(posedge lowPower) lpSeen++;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // holds the request until taken, then waits for the latch, refresh or mode write to show at the device
  task automatic send(input logic [2:0] cmd, input logic [2:0] bk, input logic [13:0] a1, a2);
    int n;
    @(posedge clk);
    reqCmd <= cmd;
    reqBank <= bk;
    reqAddr <= a1;
    reqSecond <= a2;
    reqValid <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (reqAck !== 1'b1 && n < 200);
    reqValid <= 1'b0;
    do begin @(posedge linkClk); n++; end
    while (cmdType !== 3'h1 && cmdType !== 3'h2 && cmdType !== 3'h3 && n < 240);
    if (n >= 240) begin
      fails++;
      test_done();
    end
  endtask
  function automatic logic [3:0] mask(input logic b4, input logic [1:0] v);
    if (!b4) return v[0] ? 4'h1 : 4'h3;
    case (v)
      2'h1: return 4'hF;
      2'h2: return 4'h3;
      2'h3: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_init;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while ((initDone !== 1'b1 || ready !== 1'b1) && n < 3000);
    check("ready", 16'h0001, {15'h0000, ready});
    check("refresh count ok", 16'h0001, {15'h0000, refSeen >= 2});
    check("mode write count ok", 16'h0001, {15'h0000, modeSeen >= 2});
    check("mode write bad", 16'h0000, {15'h0000, modeWriteBad});
    $display("test init done");
  endtask
  task automatic t_read;
    logic [1:0] s;
    send(3'h4, 3'h5, 14'h2AC1, 14'h01A5);
    check("read strobes", 16'h0001, {14'h0000, highLaneStrobe, lowLaneStrobe});
    check("bank", 16'h0005, {13'h0000, bankOut});
    check("upper row", 16'h2AC1, {2'h0, upperRowAddr});
    check("lower col", 16'h00A5, {8'h00, lowerColAddr});
    @(posedge linkClk);
    s = {cmd_link_if_inst.highByteStrobe, cmd_link_if_inst.lowByteStrobe};
    @(posedge linkClk);
    check("lane strobes", {14'h0000, s}, {14'h0000, highLaneStrobe, lowLaneStrobe});
    check("idle select", 16'h0001, {15'h0000, cmd_link_if_inst.chipSelN});
    $display("test read done");
  endtask
  task automatic t_write;
    logic [1:0] c, h;
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 4; i++) begin
        c = i[1:0];
        h = ~c;
        @(posedge clk);
        burstFour <= b[0];
        send(3'h5, {c[0], 2'h2}, 14'h0123, {c[1], h[0], h[1], 3'h0, 8'h3C});
        check("write strobes", 16'h0003, {14'h0000, highLaneStrobe, lowLaneStrobe});
        check("low mask", {12'h000, mask(b[0], c)}, {12'h000, lowWordMask});
        check("high mask", {12'h000, mask(b[0], h)}, {12'h000, highWordMask});
        check("write col", 16'h003C, {8'h00, lowerColAddr});
      end
    end
    $display("test write done");
  endtask
  task automatic t_sleep;
    reqSleep <= 1'b1;
    send(3'h2, 3'h0, 14'h0000, 14'h0000);
    reqSleep <= 1'b0;
    check("sleep entered", 16'h0001, {15'h0000, lpSeen == 1});
    repeat (2) @(posedge linkClk);
    check("sleep exit", 16'h0000, {15'h0000, lowPower});
    $display("test sleep done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("ready at reset", 16'h0000, {15'h0000, ready});
    t_init();
    t_read();
    t_write();
    t_sleep();
    test_done();
  end
endmodule
`default_nettype wire
